// ---- hw/gtp_port_top.sv ----
// Trigger input and tally output ports with Avalon-MM registers.
// Assumes frame_i, on_air_i and the command port come from logic on clk_i;
// pin_i is asynchronous and each pin has an external pull-up.
//
// Function
// - Input pulses under 1 ms are ignored.
// - Input ports trigger; tally ports drive outputs.
// - Falling-edge mode fires on high to low.
// - Rising-edge mode fires on low to high.
// - Edge inputs sampled and fired once per frame.
// - Each edge toggles the assigned setting.
// - Level mode acts on both transitions.
// - Level polarity selects active-high or active-low.
// - Other command sources override trigger actions.
// - Tally asserts for any chosen video inputs.
// - Tally polarity selectable; trigger mode ignored.
// - With pol at 0 (the reset value), tally idles high, drives low when active.
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
module gtp_port_top #(
  parameter int N = gtp_pkg::NUM_PORTS,
  parameter int FILT = gtp_pkg::FILTER_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [N-1:0] pin_i,
  output logic [N-1:0] pin_o,
  output logic [N-1:0] pin_oe_o,
  input wire logic frame_i,
  input wire logic [gtp_pkg::NUM_VIDEO-1:0] on_air_i,
  input wire logic cmd_valid_i,
  input wire logic [N-1:0] cmd_mask_i,
  input wire logic [N-1:0] cmd_value_i,
  output logic [N-1:0] func_o
);

  localparam int V = gtp_pkg::NUM_VIDEO;

  // Refuse port counts that the register fields cannot hold.
  if (N < 1 || N > gtp_pkg::MAX_PORTS)
  begin : g_chk
    $error("gtp_port_top: N must be 1 to 8");
  end

  // Merges write data into an old word under the byte enables.
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // Configuration registers written by software.
  logic [N-1:0] dir;       // 1 makes the port a tally output.
  logic [N-1:0] mode;      // 1 selects level trigger.
  logic [N-1:0] pol;       // Trigger edge or level, and tally polarity.
  logic [N*V-1:0] map;     // Video inputs that light each tally.
  logic [N-1:0] func;      // State of each assigned function.

  // Bus answer machine and decoded access.
  gtp_pkg::gtp_bus_state_t bus_state;
  logic bus_req;           // A read or write is present.
  logic wr_hit;            // Write takes effect this edge.
  logic [31:0] cur_word;   // Register word at the addressed offset.
  logic [31:0] new_word;   // That word after the byte-enabled write.
  logic [N-1:0] act;       // Tally condition per port.
  logic fwr;               // Software write to the function register.
  logic [N-1:0] fwr_mask;  // Ports that the write touches.
  logic [N-1:0] fwr_val;   // Values that the write gives them.

  gtp_port_if #(.N(N)) pif ();

  // Pin synchroniser and pulse filter.
  gtp_filter #(.N(N), .FILT(FILT)) u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_i),
    .pif(pif)
  );

  // Edge and level trigger decoding.
  gtp_trigger #(.N(N)) u_trigger (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pif(pif)
  );

  // Configuration handed to the trigger logic.
  assign pif.mode = mode;
  assign pif.pol = pol;
  assign pif.func = func;
  assign pif.en = ~dir;
  assign pif.frame = frame_i;
  assign func_o = func;
  assign pin_oe_o = dir;

  // Request present and write taking effect in the answer cycle.
  assign bus_req = avs_read_i || avs_write_i;
  assign wr_hit = avs_write_i && bus_state == gtp_pkg::GTP_BUS_ANS;
  // The first cycle of every request is held off by one wait state.
  assign avs_waitrequest_o =
    bus_req && bus_state == gtp_pkg::GTP_BUS_IDLE;

  // Read mux; unmapped offsets read as zero.
  always_comb
  begin
    cur_word = '0;
    unique case (avs_address_i)
      gtp_pkg::REG_DIR:
        cur_word[N-1:0] = dir;
      gtp_pkg::REG_MODE:
        cur_word[N-1:0] = mode;
      gtp_pkg::REG_POL:
        cur_word[N-1:0] = pol;
      gtp_pkg::REG_MAP:
        cur_word[N*V-1:0] = map;
      gtp_pkg::REG_STATE:
      begin
        // Filtered levels, function states and on-air inputs.
        cur_word[gtp_pkg::STATE_LVL_LSB +: N] = pif.lvl;
        cur_word[gtp_pkg::STATE_FUNC_LSB +: N] = func;
        cur_word[gtp_pkg::STATE_AIR_LSB +: V] = on_air_i;
      end
      gtp_pkg::REG_FUNC:
        cur_word[gtp_pkg::FUNC_VAL_LSB +: N] = func;
      default:
        cur_word = '0;
    endcase
  end

  // Byte-enabled write value for the addressed register.
  always_comb
  begin
    new_word = be_merge(cur_word, avs_writedata_i, avs_byteenable_i);
  end

  // Software function write: value bits under a port mask.
  always_comb
  begin
    fwr = wr_hit && avs_address_i == gtp_pkg::REG_FUNC;
    fwr_val = new_word[gtp_pkg::FUNC_VAL_LSB +: N];
    fwr_mask = new_word[gtp_pkg::FUNC_MASK_LSB +: N];
  end

  // Bus machine: one wait cycle, then the answer.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bus_state <= gtp_pkg::GTP_BUS_IDLE;
    else
    begin
      unique case (bus_state)
        gtp_pkg::GTP_BUS_IDLE:
          if (bus_req)
            bus_state <= gtp_pkg::GTP_BUS_ANS;
        gtp_pkg::GTP_BUS_ANS:
          bus_state <= gtp_pkg::GTP_BUS_IDLE;
      endcase
    end
  end

  // Read data is caught in the wait cycle and stands afterwards.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      avs_readdata_o <= '0;
    else if (avs_read_i && bus_state == gtp_pkg::GTP_BUS_IDLE)
      avs_readdata_o <= cur_word;
  end

  // Direction, trigger mode and polarity registers.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dir <= {N{gtp_pkg::RST_DIR}};
      mode <= {N{gtp_pkg::RST_MODE}};
      pol <= {N{gtp_pkg::RST_POL}};
    end
    else if (wr_hit)
    begin
      if (avs_address_i == gtp_pkg::REG_DIR)
        dir <= new_word[N-1:0];
      if (avs_address_i == gtp_pkg::REG_MODE)
        mode <= new_word[N-1:0];
      if (avs_address_i == gtp_pkg::REG_POL)
        pol <= new_word[N-1:0];
    end
  end

  // Tally source map, four video inputs per port.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      map <= {(N*V){gtp_pkg::RST_MAP}};
    else if (wr_hit && avs_address_i == gtp_pkg::REG_MAP)
      map <= new_word[N*V-1:0];
  end

  // Function state: command port, then software, then triggers.
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (rst_i)
        func[i] <= gtp_pkg::RST_FUNC;
      else if (cmd_valid_i && cmd_mask_i[i])
        func[i] <= cmd_value_i[i];
      else if (fwr && fwr_mask[i])
        func[i] <= fwr_val[i];
      else if (pif.req[i])
        func[i] <= pif.val[i];
    end
  end

  // Tally condition: any mapped video input on air.
  always_comb
  begin
    for (int i = 0; i < N; i++)
      act[i] = |(map[i*V +: V] & on_air_i);
  end

  // Tally pin level; trigger mode plays no part here.
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (rst_i)
        pin_o[i] <= gtp_pkg::IDLE_LEVEL;
      else if (dir[i])
        pin_o[i] <= pol[i] ~^ act[i];
      else
        pin_o[i] <= gtp_pkg::IDLE_LEVEL;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  bus_wait_a: assert property (bus_req && avs_waitrequest_o |=>
    !avs_waitrequest_o)
    else $error("Bus answer took more than one wait cycle");

  // Read data handed over in the answer cycle is the word that was
  // addressed in the wait cycle before it.
  read_data_a: assert property (avs_read_i && !avs_waitrequest_o |->
    avs_readdata_o == $past(cur_word))
    else $error("Read data not the addressed word");

  // A direction write lands at the answer edge.
  dir_land_a: assert property (wr_hit &&
    avs_address_i == gtp_pkg::REG_DIR |=> dir == $past(new_word[N-1:0]))
    else $error("Direction write lost");

  // A map write lands in the tally map at the answer edge.
  map_land_a: assert property (wr_hit &&
    avs_address_i == gtp_pkg::REG_MAP |=> map == $past(new_word[N*V-1:0]))
    else $error("Tally map write lost");

  for (genvar g = 0; g < N; g++)
  begin : g_port_chk
    cmd_win_a: assert property (cmd_valid_i && cmd_mask_i[g] |=>
      func[g] == $past(cmd_value_i[g]))
      else $error("Command did not override function");
    trig_apply_a: assert property (pif.req[g] &&
      !(cmd_valid_i && cmd_mask_i[g]) && !(fwr && fwr_mask[g]) |=>
      func[g] == $past(pif.val[g]))
      else $error("Trigger request not applied");
    // An input port leaves its pin undriven and at the idle level.
    input_quiet_a: assert property (!dir[g] |->
      !pin_oe_o[g] ##1 pin_o[g])
      else $error("Input port drove its pin");
    // A tally port raises no trigger request in the next cycle.
    tally_noreq_a: assert property (dir[g] |=> !pif.req[g])
      else $error("Tally port raised a trigger request");
    // A software function write beats a trigger in the same cycle.
    fwr_win_a: assert property (fwr && fwr_mask[g] &&
      !(cmd_valid_i && cmd_mask_i[g]) |=> func[g] == $past(fwr_val[g]))
      else $error("Function write did not override trigger");
    tally_drive_a: assert property (dir[g] |=>
      pin_o[g] == ($past(pol[g]) ~^ $past(act[g])))
      else $error("Tally level wrong");
    tally_low_a: assert property (dir[g] && !pol[g] && act[g] &&
      $stable(dir[g]) ##1 dir[g] |-> !pin_o[g])
      else $error("Default tally not low when active");
  end

endmodule

// ---- hw/gtp_pkg.sv ----
// Constants shared by the trigger and tally port logic.
// Assumes a 20 MHz system clock and byte-addressed Avalon-MM registers.
package gtp_pkg;

  // System clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 50;
  // Shortest input pulse that is accepted, in nanoseconds (1 ms).
  localparam int FILTER_MIN_NS = 1000000;
  // Filter length in clock cycles, rounded up.
  localparam int FILTER_CYCLES =
    (FILTER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Default number of ports and the number of video inputs.
  localparam int NUM_PORTS = 4;
  localparam int NUM_VIDEO = 4;
  // Widest port count that the register layout can hold.
  localparam int MAX_PORTS = 8;

  // Register byte offsets.
  localparam logic [4:0] REG_DIR = 5'h00;
  localparam logic [4:0] REG_MODE = 5'h04;
  localparam logic [4:0] REG_POL = 5'h08;
  localparam logic [4:0] REG_MAP = 5'h0c;
  localparam logic [4:0] REG_STATE = 5'h10;
  localparam logic [4:0] REG_FUNC = 5'h14;

  // Field positions inside the state and function registers.
  localparam int FUNC_VAL_LSB = 0;
  localparam int FUNC_MASK_LSB = 8;
  localparam int STATE_LVL_LSB = 0;
  localparam int STATE_FUNC_LSB = 8;
  localparam int STATE_AIR_LSB = 16;

  // Values after reset.
  localparam logic RST_DIR = 1'b0;
  localparam logic RST_MODE = 1'b0;
  localparam logic RST_POL = 1'b0;
  localparam logic RST_MAP = 1'b0;
  localparam logic RST_FUNC = 1'b0;
  localparam logic IDLE_LEVEL = 1'b1;

  // Bus answer states.
  typedef enum logic {GTP_BUS_IDLE, GTP_BUS_ANS} gtp_bus_state_t;

endpackage

// ---- hw/gtp_port_if.sv ----
// Interface between the port top, the input filter and the trigger logic.
// Assumes all three sit on the same system clock.
`timescale 1ns/1ns
interface gtp_port_if #(parameter int N = 4);
  logic [N-1:0] lvl;   // Filtered input level.
  logic [N-1:0] mode;  // 1 selects level trigger, 0 edge trigger.
  logic [N-1:0] pol;   // 1 selects rising or active-high.
  logic [N-1:0] func;  // Present state of each assigned function.
  logic [N-1:0] en;    // Trigger enabled (port set as input).
  logic [N-1:0] req;   // One-cycle request to update a function.
  logic [N-1:0] val;   // Value requested with req.
  logic frame;         // Once-per-frame strobe.

  // Filter drives the clean level.
  modport filt (output lvl);
  // Trigger turns levels into requests.
  modport trig (input lvl, mode, pol, func, en, frame, output req, val);
  // Top supplies configuration and consumes requests.
  modport top (input lvl, req, val, output mode, pol, func, en, frame);
endinterface

// ---- hw/gtp_filter.sv ----
// Two-stage synchroniser and minimum-width pulse filter for each input pin.
// Assumes pins are asynchronous to clk_i.
`timescale 1ns/1ns
module gtp_filter #(
  parameter int N = 4,
  parameter int FILT = gtp_pkg::FILTER_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] pin_i,
  gtp_port_if.filt pif
);

  localparam int CW = $clog2(FILT);

  // Refuse a filter too short for the counter to work.
  if (FILT < 2)
  begin : g_chk
    $error("gtp_filter: FILT must be at least 2");
  end

  logic [N-1:0] s1;          // First synchroniser stage.
  logic [N-1:0] s2;          // Second synchroniser stage.
  logic [CW-1:0] cnt [N];    // Cycles that s2 has differed from lvl.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Synchroniser: s1 is read only by s2.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1 <= {N{gtp_pkg::IDLE_LEVEL}};
      s2 <= {N{gtp_pkg::IDLE_LEVEL}};
    end
    else
    begin
      s1 <= pin_i;
      s2 <= s1;
    end
  end

  // Filter: a new level is taken after FILT stable cycles.
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (rst_i)
      begin
        pif.lvl[i] <= gtp_pkg::IDLE_LEVEL;
        cnt[i] <= '0;
      end
      else if (s2[i] == pif.lvl[i])
        cnt[i] <= '0;
      else if (cnt[i] == CW'(FILT - 1))
      begin
        pif.lvl[i] <= s2[i];
        cnt[i] <= '0;
      end
      else
        cnt[i] <= cnt[i] + 1'b1;
    end
  end

  for (genvar g = 0; g < N; g++)
  begin : g_chk_port
    filt_len_a: assert property ($changed(pif.lvl[g]) |->
      $past(cnt[g]) == CW'(FILT - 1))
      else $error("Level accepted before minimum width");
    sync_path_a: assert property ($changed(pif.lvl[g]) |->
      pif.lvl[g] == $past(s2[g]))
      else $error("Level did not come from second stage");
  end

endmodule

// ---- hw/gtp_trigger.sv ----
// Turns filtered levels into function requests, by edge or by level.
// Assumes frame is a one-cycle strobe on the same clock.
`timescale 1ns/1ns
module gtp_trigger #(
  parameter int N = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  gtp_port_if.trig pif
);

  logic [N-1:0] samp;   // Level seen at the previous frame strobe.
  logic [N-1:0] lprev;  // Level seen in the previous cycle.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Frame and cycle history of each level.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      samp <= {N{gtp_pkg::IDLE_LEVEL}};
      lprev <= {N{gtp_pkg::IDLE_LEVEL}};
    end
    else
    begin
      if (pif.frame)
        samp <= pif.lvl;
      lprev <= pif.lvl;
    end
  end

  // Request generation, registered one cycle after its cause.
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (rst_i)
      begin
        pif.req[i] <= 1'b0;
        pif.val[i] <= 1'b0;
      end
      else if (!pif.en[i])
        pif.req[i] <= 1'b0;
      else if (pif.mode[i])
      begin
        // Level mode acts on every change in either direction.
        pif.req[i] <= pif.lvl[i] != lprev[i];
        pif.val[i] <= pif.lvl[i] ~^ pif.pol[i];
      end
      else
      begin
        // Edge mode looks only at frame strobes, so once per frame.
        pif.req[i] <= pif.frame && (pif.pol[i] ?
          (!samp[i] && pif.lvl[i]) :
          (samp[i] && !pif.lvl[i]));
        pif.val[i] <= !pif.func[i];
      end
    end
  end

  for (genvar g = 0; g < N; g++)
  begin : g_chk
    sequence edge_cfg;
      pif.en[g] && !pif.mode[g] && pif.frame;
    endsequence
    sequence fall_seen;
      edge_cfg ##0 !pif.pol[g] && samp[g] && !pif.lvl[g];
    endsequence
    sequence rise_seen;
      edge_cfg ##0 pif.pol[g] && !samp[g] && pif.lvl[g];
    endsequence
    fall_fire_a: assert property (fall_seen |=> pif.req[g])
      else $error("Falling edge did not fire");
    rise_fire_a: assert property (rise_seen |=> pif.req[g])
      else $error("Rising edge did not fire");
    frame_once_a: assert property (
      pif.req[g] && !$past(pif.mode[g]) |-> $past(pif.frame))
      else $error("Edge request outside a frame strobe");
    level_val_a: assert property (
      pif.en[g] && pif.mode[g] && $changed(pif.lvl[g]) |=>
      pif.req[g] && pif.val[g] == ($past(pif.lvl[g]) ~^ $past(pif.pol[g])))
      else $error("Level request wrong");
  end

endmodule

// ---- testbench/gtp_switch_model.sv ----
// Push buttons or outside gear on each port line, with pull-ups.
// Assumes the bench calls set_low to close or open a switch.
`timescale 1ns/1ns
module gtp_switch_model #(
  parameter int N = 4
) (
  input wire logic clk_i,
  input wire logic [N-1:0] drv_i,
  input wire logic [N-1:0] oe_i,
  output logic [N-1:0] line_o
);
  // One bit per port, set while the switch grounds the line.
  logic [N-1:0] pull_low = '0;

  // A driving tally pin sets the line; otherwise the switch or pull-up.
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      line_o[i] = (oe_i[i] === 1'b1) ? drv_i[i] : !pull_low[i];
    end
  end

  // Closes or opens one switch just after a clock edge.
  task automatic set_low(input int idx, input bit low);
    @(posedge clk_i);
    pull_low[idx] <= low;
  endtask
endmodule

// ---- testbench/tb_gpi_tally_port_logic.sv ----
// Self-checking bench for the trigger and tally port block.
// Assumes a short filter (8 cycles) and a switch model on the pins.
`timescale 1ns/1ns
module tb_gpi_tally_port_logic;
  localparam int N = 4;
  localparam int FILT = 8;
  // Cycles for a pin change to pass synchroniser, filter and trigger.
  localparam int SETTLE = FILT + 6;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [N-1:0] pin_i;
  logic [N-1:0] pin_o;
  logic [N-1:0] pin_oe_o;
  logic [N-1:0] func_o;
  logic frame_i = 1'b0;
  logic [3:0] on_air_i = '0;
  logic cmd_valid_i = 1'b0;
  logic [N-1:0] cmd_mask_i = '0;
  logic [N-1:0] cmd_value_i = '0;
  int bad_count = 0;
  int n_tests = 0;
  int ef = 0; // Model of the function states.
  logic [31:0] rd; // Last read data.
  logic [31:0] rm; // Random tally map.
  logic [31:0] rp; // Random polarity.
  logic [31:0] ra; // Random on-air set.
  logic [N-1:0] et; // Expected tally levels.

  // The system clock, 50 ns period.
  always #25 clk_i = ~clk_i;

  gtp_port_top #(.N(N), .FILT(FILT)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .frame_i(frame_i),
    .on_air_i(on_air_i), .cmd_valid_i(cmd_valid_i), .cmd_mask_i(cmd_mask_i),
    .cmd_value_i(cmd_value_i), .func_o(func_o));

  gtp_switch_model #(.N(N)) sw (
    .clk_i(clk_i), .drv_i(pin_o), .oe_i(pin_oe_o), .line_o(pin_i));

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One Avalon transfer, held until waitrequest is seen low at a rising
  // edge; read data is taken and the request released at that same edge.
  task automatic bus(input bit wr, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do
    begin
      @(posedge clk_i);
    end
    while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  // Full-word register write.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  // Reads a register and compares it with the model.
  task automatic chk_reg(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    n_tests++;
    if (rd !== exp)
    begin
      bad_count++;
      $display("Error reg %h expected %h seen %h", a, exp, rd);
    end
  endtask

  // Compares a port-wide output with the model.
  task automatic chk_port(input string nm, input logic [N-1:0] exp,
                          input logic [N-1:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Issues one frame strobe and lets the request land.
  task automatic frame();
    @(posedge clk_i);
    frame_i <= 1'b1;
    @(posedge clk_i);
    frame_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // Moves one switch and waits for the filtered level to settle.
  task automatic press(input int idx, input bit low);
    sw.set_low(idx, low);
    repeat (SETTLE) @(posedge clk_i);
  endtask

  // Cuts a hang short.
  initial
  begin
    #(50 * 20000);
    bad_count++;
    $display("Error watchdog expected finish seen timeout");
    conclude();
  end

  // Main sequence.
  initial
  begin
    rd = $urandom(32'h9437);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_port("pin", 4'hf, pin_o);
    chk_port("oe", 4'h0, pin_oe_o);
    chk_reg(gtp_pkg::REG_DIR, 32'h0);
    chk_reg(gtp_pkg::REG_MODE, 32'h0);
    chk_reg(gtp_pkg::REG_POL, 32'h0);
    chk_reg(gtp_pkg::REG_MAP, 32'h0);
    chk_reg(gtp_pkg::REG_STATE, 32'hf);
    chk_reg(5'h18, 32'h0);
    // A seven-cycle dip must vanish in the filter.
    sw.set_low(0, 1'b1);
    repeat (FILT - 2) @(posedge clk_i);
    press(0, 1'b0);
    frame();
    chk_reg(gtp_pkg::REG_STATE, 32'hf);
    chk_port("func", ef[N-1:0], func_o);
    // Falling edge on port 0 fires only at the frame strobe.
    press(0, 1'b1);
    chk_port("func", ef[N-1:0], func_o);
    frame();
    ef[0] = 1;
    chk_port("func", ef[N-1:0], func_o);
    frame();
    chk_port("func", ef[N-1:0], func_o);
    press(0, 1'b0);
    frame();
    chk_port("func", ef[N-1:0], func_o);
    press(0, 1'b1);
    frame();
    ef[0] = 0;
    chk_port("func", ef[N-1:0], func_o);
    press(0, 1'b0);
    // Rising edge on port 1 ignores the press, fires on release.
    wr(gtp_pkg::REG_POL, 32'h2);
    press(1, 1'b1);
    frame();
    chk_port("func", ef[N-1:0], func_o);
    press(1, 1'b0);
    frame();
    ef[1] = 1;
    chk_port("func", ef[N-1:0], func_o);
    // Level mode: port 2 active high, port 3 active low.
    wr(gtp_pkg::REG_MODE, 32'hc);
    wr(gtp_pkg::REG_POL, 32'h6);
    bus(1'b1, gtp_pkg::REG_MODE, 32'h0, 4'h0);
    chk_reg(gtp_pkg::REG_MODE, 32'hc);
    wr(gtp_pkg::REG_FUNC, 32'h0404);
    ef[2] = 1;
    chk_reg(gtp_pkg::REG_FUNC, ef);
    press(2, 1'b1);
    ef[2] = 0;
    chk_port("func", ef[N-1:0], func_o);
    press(2, 1'b0);
    ef[2] = 1;
    chk_port("func", ef[N-1:0], func_o);
    press(3, 1'b1);
    ef[3] = 1;
    chk_port("func", ef[N-1:0], func_o);
    press(3, 1'b0);
    ef[3] = 0;
    chk_port("func", ef[N-1:0], func_o);
    // An outside command sets only the masked port.
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_mask_i <= 4'h1;
    cmd_value_i <= 4'hf;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    ef[0] = 1;
    repeat (2) @(posedge clk_i);
    chk_port("func", ef[N-1:0], func_o);
    // All ports as tallies with random maps, polarities and modes.
    wr(gtp_pkg::REG_DIR, 32'hf);
    for (int t = 0; t < 16; t++)
    begin
      rm = $urandom;
      rp = $urandom;
      ra = $urandom;
      wr(gtp_pkg::REG_MAP, {16'h0, rm[15:0]});
      wr(gtp_pkg::REG_POL, {28'h0, rp[3:0]});
      wr(gtp_pkg::REG_MODE, {28'h0, ra[7:4]});
      @(posedge clk_i);
      on_air_i <= ra[3:0];
      frame();
      repeat (SETTLE) @(posedge clk_i);
      for (int i = 0; i < N; i++)
      begin
        et[i] = rp[i] ~^ (|(rm[4*i +: 4] & ra[3:0]));
      end
      chk_port("tally", et, pin_o);
      chk_port("func", ef[N-1:0], func_o);
    end
    chk_port("oe", 4'hf, pin_oe_o);
    conclude();
  end
endmodule
